/* hdl/vtr_map.vh */
`ifndef VTR_MAP_VH
`define VTR_MAP_VH

// register addresses at the serial port
`define VTR_ADDR_TRIM      8'h00
`define VTR_ADDR_PTR       8'h02

// pointer field: only this bit is decoded
`define VTR_PTR_SEL_BIT    7

// reset, factory and error values
`define VTR_WIPER_RESET    8'h80
`define VTR_PTR_RESET      8'h00
`define VTR_FACTORY_INIT   8'h80
`define VTR_ERROR_SETTING  8'h80

// seven-bit bus identification, byte sent msb first
`define VTR_BUS_ID         7'h28

// timing
`define VTR_CLK_FREQ_MHZ   125
`define VTR_LOAD_TIME_NS   120000
`define VTR_NV_WRITE_NS    10000
`define VTR_LOAD_CYCLES    (`VTR_LOAD_TIME_NS * `VTR_CLK_FREQ_MHZ / 1000)
`define VTR_NV_CYCLES      (`VTR_NV_WRITE_NS * `VTR_CLK_FREQ_MHZ / 1000)

`endif

/* hdl/vtr_sync.v */
`timescale 1ns/10ps
`default_nettype none

// three-stage synchroniser; output moves only when stages two and three agree
module vtr_sync (
	input  wire clk_i,    // sampling clock
	input  wire nrst_i,   // async reset, active low
	input  wire async_i,  // pin level
	output reg  level_o   // filtered level
);
	reg s1_q;
	reg s2_q;
	reg s3_q;

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s1_q    <= 1'b1;
			s2_q    <= 1'b1;
			s3_q    <= 1'b1;
			level_o <= 1'b1;
		end else begin
			s1_q <= async_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level_o <= s3_q;
			end
		end
	end
endmodule // vtr_sync

`default_nettype wire

/* hdl/vtr_top.v */
`timescale 1ns/10ps
`default_nettype none
`include "vtr_map.vh"

// Functional notes
// - The trim output follows the wiper register alone, and wiper accesses never touch the stored setting.
// - After power-up the stored setting is copied into the wiper register.
// - A write to the stored setting loads the same byte into the wiper at once; the stored setting itself changes only at the end of the nonvolatile write.
// - The wiper is an 8-bit code with 256 steps.
// - The sink current code is 255 minus the setting, so 255 sinks nothing.
// - The factory stored setting is 128.
// - An invalid address byte, or a start or stop inside a byte, forces the wiper back to 128; a bad id byte does not.
// - After power-up the block spends 120 us loading its settings before it answers the bus.
// - Every byte on the bus travels most significant bit first.
// - The pointer register is volatile and resets to 00h.
// - The block acknowledges a valid id byte, a valid address byte (00h or 02h) and every written data byte.
// - A stop after writing address 0 with pointer zero starts a nonvolatile write, during which the bus is ignored.
module vtr_top #(
	parameter [23:0] LOAD_CYCLES = `VTR_LOAD_CYCLES, // settings load time
	parameter [23:0] NV_CYCLES   = `VTR_NV_CYCLES    // nonvolatile write time
) (
	input  wire       MCLK_I,        // 125 MHz clock
	input  wire       NRST_I,        // async reset, active low (power-up)
	input  wire       SCL_I,         // serial clock pin
	input  wire       SDA_I,         // serial data pin level
	output wire       SDA_O,         // serial data drive value, always low
	output reg        SDA_OE_O,      // high while pulling data low
	output wire [7:0] TRIM_CODE_O,   // wiper setting to the trim dac
	output wire [7:0] SINK_CODE_O,   // 255 minus setting, sink current
	output wire       LOAD_BUSY_O,   // settings load in progress
	output wire       NV_BUSY_O      // nonvolatile write in progress
);
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_ID   = 3'h1;
	localparam [2:0] ST_REG  = 3'h2;
	localparam [2:0] ST_WDAT = 3'h3;
	localparam [2:0] ST_RDAT = 3'h4;
	localparam [2:0] ST_SKIP = 3'h5;

	wire scl;
	wire sda;
	reg  scl_q;
	reg  sda_q;
	reg  [2:0]  state_q;
	reg  [3:0]  cnt_q;
	reg         ack_q;
	reg  [7:0]  sh_q;
	reg  [7:0]  tx_q;
	reg  [7:0]  addr_q;
	reg  [7:0]  wiper_q;
	reg  [7:0]  nv_q = `VTR_FACTORY_INIT;
	reg  [7:0]  ptr_q;
	reg  [7:0]  nv_data_q;
	reg         nv_pend_q;
	reg  [23:0] load_cnt_q;
	reg  [23:0] nv_cnt_q;

	vtr_sync u_scl_sync (
		.clk_i   (MCLK_I),
		.nrst_i  (NRST_I),
		.async_i (SCL_I),
		.level_o (scl)
	);

	vtr_sync u_sda_sync (
		.clk_i   (MCLK_I),
		.nrst_i  (NRST_I),
		.async_i (SDA_I),
		.level_o (sda)
	);

	wire scl_rise = scl & ~scl_q;
	wire scl_fall = ~scl & scl_q;
	wire start_c  = scl & scl_q & sda_q & ~sda;
	wire stop_c   = scl & scl_q & ~sda_q & sda;
	wire busy     = (load_cnt_q != 24'h000000) | (nv_cnt_q != 24'h000000);
	wire active   = (state_q != ST_IDLE) & (state_q != ST_SKIP);
	// a start or stop is clean only on a byte boundary; the rise that carries it
	// has already clocked one bit in, so a count of 1 is still a boundary
	wire mid_byte = (cnt_q > 4'h1) | ack_q;
	wire [7:0] rd_word = (addr_q == `VTR_ADDR_PTR) ? ptr_q :
	                     (ptr_q[`VTR_PTR_SEL_BIT] ? wiper_q : nv_q);

	assign SDA_O       = 1'b0;
	assign TRIM_CODE_O = wiper_q;
	assign SINK_CODE_O = 8'hFF - wiper_q;
	assign LOAD_BUSY_O = (load_cnt_q != 24'h000000);
	assign NV_BUSY_O   = (nv_cnt_q != 24'h000000);

	always @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			scl_q      <= 1'b1;
			sda_q      <= 1'b1;
			state_q    <= ST_IDLE;
			cnt_q      <= 4'h0;
			ack_q      <= 1'b0;
			sh_q       <= 8'h00;
			tx_q       <= 8'h00;
			addr_q     <= 8'h00;
			SDA_OE_O   <= 1'b0;
			wiper_q    <= `VTR_WIPER_RESET;
			ptr_q      <= `VTR_PTR_RESET;
			nv_data_q  <= 8'h00;
			nv_pend_q  <= 1'b0;
			load_cnt_q <= LOAD_CYCLES;
			nv_cnt_q   <= 24'h000000;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (load_cnt_q != 24'h000000) begin
				load_cnt_q <= load_cnt_q - 24'h000001;
				if (load_cnt_q == 24'h000001) begin
					wiper_q <= nv_q;
				end
			end
			if (nv_cnt_q != 24'h000000) begin
				nv_cnt_q <= nv_cnt_q - 24'h000001;
			end
			if (busy) begin
				// bus is ignored and data released while loading or writing
				state_q  <= ST_IDLE;
				cnt_q    <= 4'h0;
				ack_q    <= 1'b0;
				SDA_OE_O <= 1'b0;
			end else if (start_c) begin
				if (active & mid_byte) begin
					wiper_q   <= `VTR_ERROR_SETTING;
					nv_pend_q <= 1'b0;
				end
				state_q  <= ST_ID;
				cnt_q    <= 4'h0;
				ack_q    <= 1'b0;
				SDA_OE_O <= 1'b0;
			end else if (stop_c) begin
				if (active & mid_byte) begin
					wiper_q <= `VTR_ERROR_SETTING;
				end else if (nv_pend_q) begin
					nv_cnt_q <= NV_CYCLES;
				end
				nv_pend_q <= 1'b0;
				state_q   <= ST_IDLE;
				cnt_q     <= 4'h0;
				ack_q     <= 1'b0;
				SDA_OE_O  <= 1'b0;
			end else if (active & scl_rise) begin
				if (ack_q) begin
					// master nack ends the read, ack asks for another byte
					if ((state_q == ST_RDAT) & sda) begin
						state_q <= ST_SKIP;
					end
				end else if (cnt_q != 4'h8) begin
					sh_q  <= {sh_q[6:0], sda};
					cnt_q <= cnt_q + 4'h1;
				end
			end else if (active & scl_fall) begin
				if (ack_q) begin
					ack_q <= 1'b0;
					cnt_q <= 4'h0;
					if (state_q == ST_RDAT) begin
						tx_q     <= rd_word;
						SDA_OE_O <= ~rd_word[7];
					end else begin
						SDA_OE_O <= 1'b0;
					end
				end else if (state_q == ST_RDAT) begin
					if (cnt_q == 4'h8) begin
						SDA_OE_O <= 1'b0;
						ack_q    <= 1'b1;
					end else if (cnt_q != 4'h0) begin
						tx_q     <= {tx_q[6:0], 1'b0};
						SDA_OE_O <= ~tx_q[6];
					end
				end else if (cnt_q == 4'h8) begin
					ack_q <= 1'b1;
					case (state_q)
						ST_ID: begin
							if (sh_q[7:1] == `VTR_BUS_ID) begin
								SDA_OE_O <= 1'b1;
								state_q  <= sh_q[0] ? ST_RDAT : ST_REG;
							end else begin
								state_q <= ST_SKIP;
							end
						end
						ST_REG: begin
							if ((sh_q == `VTR_ADDR_TRIM) | (sh_q == `VTR_ADDR_PTR)) begin
								SDA_OE_O <= 1'b1;
								addr_q   <= sh_q;
								state_q  <= ST_WDAT;
							end else begin
								// reserved or unknown address
								wiper_q <= `VTR_ERROR_SETTING;
								state_q <= ST_SKIP;
							end
						end
						ST_WDAT: begin
							SDA_OE_O <= 1'b1;
							if (addr_q == `VTR_ADDR_PTR) begin
								ptr_q <= sh_q;
							end else begin
								wiper_q <= sh_q;
								if (!ptr_q[`VTR_PTR_SEL_BIT]) begin
									nv_data_q <= sh_q;
									nv_pend_q <= 1'b1;
								end
							end
						end
						default: begin
							state_q <= ST_SKIP;
						end
					endcase
				end
			end
		end
	end

	// nonvolatile store: no reset, a programmed setting must survive power-up
	always @(posedge MCLK_I) begin
		if (nv_cnt_q == 24'h000001) begin
			nv_q <= nv_data_q;
		end
	end
endmodule // vtr_top

`default_nettype wire

/* tb/vtr_top_chk.sv */
`timescale 1ns/10ps
`default_nettype none

module vtr_chk #(
	parameter [23:0] LOAD_CYCLES = 24'd20, // settings load time
	parameter [23:0] NV_CYCLES   = 24'd20  // nonvolatile write time
) (
	input wire       MCLK_I,      // clock
	input wire       NRST_I,      // reset, active low
	input wire       SCL_I,       // serial clock
	input wire       SDA_I,       // data wire
	input wire       SDA_O,       // drive value
	input wire       SDA_OE_O,    // pull enable
	input wire [7:0] TRIM_CODE_O, // wiper
	input wire [7:0] SINK_CODE_O, // sink code
	input wire       LOAD_BUSY_O, // load busy
	input wire       NV_BUSY_O    // nv busy
);
	logic [23:0] load_cnt_q;
	logic [23:0] nv_cnt_q;
	logic [7:0]  nv_shadow_q = 8'h80; // factory setting

	// stored setting outlives reset, so its shadow has none
	always @(posedge MCLK_I) begin
		if (NRST_I && !NV_BUSY_O && nv_cnt_q != 24'h0) begin
			nv_shadow_q <= TRIM_CODE_O;
		end
	end

	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			load_cnt_q <= 24'h0;
			nv_cnt_q   <= 24'h0;
		end else begin
			load_cnt_q <= LOAD_BUSY_O ? load_cnt_q + 24'h1 : load_cnt_q;
			nv_cnt_q   <= NV_BUSY_O ? nv_cnt_q + 24'h1 : 24'h0;
		end
	end

	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!NRST_I);

	sink_code_a: assert property (SINK_CODE_O == 8'hFF - TRIM_CODE_O)
		else $error("sink code is not 255 minus trim");
	busy_quiet_a: assert property ((LOAD_BUSY_O || NV_BUSY_O) |-> !SDA_OE_O)
		else $error("data driven while busy");
	od_low_a: assert property (SDA_O == 1'b0)
		else $error("data drive value not low");
	load_len_a: assert property ($fell(LOAD_BUSY_O) |-> load_cnt_q + 24'h1 >= LOAD_CYCLES && load_cnt_q <= LOAD_CYCLES + 24'h1)
		else $error("load time off");
	load_trim_a: assert property ($fell(LOAD_BUSY_O) |-> TRIM_CODE_O == nv_shadow_q)
		else $error("wiper not recalled at end of load");
	nv_max_a: assert property (nv_cnt_q <= NV_CYCLES + 24'h1)
		else $error("nv write too long");
	nv_min_a: assert property ($fell(NV_BUSY_O) |-> nv_cnt_q + 24'h1 >= NV_CYCLES)
		else $error("nv write too short");
	nv_hold_a: assert property (NV_BUSY_O && $past(NV_BUSY_O) |-> $stable(TRIM_CODE_O))
		else $error("wiper moved during nv write");
	ack_hold_a: assert property ($rose(SDA_OE_O) |-> SDA_OE_O[*8])
		else $error("pull shorter than a bit");

	cover property ($rose(NV_BUSY_O));
	cover property ($rose(SDA_OE_O));
	cover property ($fell(LOAD_BUSY_O));
endmodule // vtr_chk

bind vtr_top vtr_chk #(.LOAD_CYCLES(LOAD_CYCLES), .NV_CYCLES(NV_CYCLES)) chk_u (
	.MCLK_I(MCLK_I), .NRST_I(NRST_I), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O),
	.SDA_OE_O(SDA_OE_O), .TRIM_CODE_O(TRIM_CODE_O), .SINK_CODE_O(SINK_CODE_O),
	.LOAD_BUSY_O(LOAD_BUSY_O), .NV_BUSY_O(NV_BUSY_O)
);

`default_nettype wire

/* tb/vtr_mst.sv */
`timescale 1ns/10ps
`default_nettype none

// clock idles high between frames; a bit is 8 clocks, 6 low and 2 high, so the
// slave's answer, about 5 clocks after a fall, settles before the next rise
module vtr_mst (
	input  wire  clk_i, // bench clock, pins move just after its rise
	output logic scl_o, // serial clock
	output logic sda_o, // 0 pulls data low
	input  wire  sda_i  // resolved wire
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// from idle or after a bit; ends with the clock pulled low
	task automatic start;
		wait_clk(1);
		sda_o <= 1'b1;
		wait_clk(5);
		scl_o <= 1'b1;
		wait_clk(4);
		sda_o <= 1'b0;
		wait_clk(4);
		scl_o <= 1'b0;
	endtask
	// tail gives the slave time to see the stop before anyone looks
	task automatic stop;
		wait_clk(1);
		sda_o <= 1'b0;
		wait_clk(5);
		scl_o <= 1'b1;
		wait_clk(4);
		sda_o <= 1'b1;
		wait_clk(8);
	endtask
	task automatic bit_x(input logic b, output logic s);
		wait_clk(1);
		sda_o <= b;
		wait_clk(5);
		scl_o <= 1'b1;
		wait_clk(2);
		s = sda_i;
		scl_o <= 1'b0;
	endtask
	// ack slot always released, so a read byte ends unacknowledged
	task automatic xbyte(input logic [7:0] w, output logic [7:0] r, output logic ack);
		for (int i = 7; i >= 0; i--) bit_x(w[i], r[i]);
		bit_x(1'b1, ack);
		ack = ~ack;
	endtask
endmodule // vtr_mst

`default_nettype wire

/* tb/panel_common_voltage_trim_register_access_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "vtr_map.vh"

module panel_common_voltage_trim_register_access_bench;
	logic mclk, nrst_n, scl, msda, a;
	logic [7:0] d, r, v;
	wire sda_w, sda_o, sda_oe, load_busy, nv_busy;
	wire [7:0] trim, sink;
	int num_errors, samples_checked;
	localparam logic [7:0] ID_W = {`VTR_BUS_ID, 1'b0};

	assign sda_w = (sda_oe ? sda_o : 1'b1) & msda;
	vtr_top #(.LOAD_CYCLES(24'd20), .NV_CYCLES(24'd200)) dut_u (.MCLK_I(mclk), .NRST_I(nrst_n),
		.SCL_I(scl), .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE_O(sda_oe), .TRIM_CODE_O(trim),
		.SINK_CODE_O(sink), .LOAD_BUSY_O(load_busy), .NV_BUSY_O(nv_busy));
	vtr_mst mst_u (.clk_i(mclk), .scl_o(scl), .sda_o(msda), .sda_i(sda_w));

	function automatic logic [7:0] sink_of(input logic [7:0] v);
		return 8'hFF - v;
	endfunction
	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic idle_wait;
		int n;
		n = 0;
		while ((load_busy | nv_busy) !== 1'b0 && n < 400) begin
			@(posedge mclk);
			n++;
		end
		if (n == 400) begin
			num_errors++;
			stop_test();
		end
	endtask
	task automatic wr(input logic [7:0] adr, input logic [7:0] dat, input logic ok);
		mst_u.start();
		mst_u.xbyte(ID_W, r, a);
		chk("id ack", {7'h0, a}, 8'h01);
		mst_u.xbyte(adr, r, a);
		chk("adr ack", {7'h0, a}, {7'h0, ok});
		if (ok) begin
			mst_u.xbyte(dat, r, a);
			chk("dat ack", {7'h0, a}, 8'h01);
		end
		mst_u.stop();
	endtask
	task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
		mst_u.start();
		mst_u.xbyte(ID_W, r, a);
		mst_u.xbyte(adr, r, a);
		mst_u.start();
		mst_u.xbyte(ID_W | 8'h01, r, a);
		mst_u.xbyte(8'hFF, r, a);
		chk("rd data", r, exp);
		mst_u.stop();
	endtask

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		nrst_n = 1'b0;
		num_errors = 0;
		samples_checked = 0;
		void'($urandom(32'h52BC1C0B));
		repeat (12) @(posedge mclk);
		chk("trim rst", trim, `VTR_WIPER_RESET);
		chk("sink rst", sink, 8'h7F);
		nrst_n <= 1'b1;
		@(posedge mclk);
		idle_wait();
		chk("trim load", trim, `VTR_FACTORY_INIT);
		wr(`VTR_ADDR_PTR, 8'h80, 1'b1);
		for (int k = 0; k < 4; k++) begin
			d = (k == 0) ? 8'hFF : ((k == 1) ? 8'h00 : 8'($urandom));
			wr(`VTR_ADDR_TRIM, d, 1'b1);
			chk("trim", trim, d);
			chk("sink", sink, sink_of(d));
			rd(`VTR_ADDR_TRIM, d);
		end
		rd(`VTR_ADDR_PTR, 8'h80);
		wr(`VTR_ADDR_PTR, 8'h00, 1'b1);
		rd(`VTR_ADDR_TRIM, `VTR_FACTORY_INIT);
		$display("test wiper only done");
		d = 8'($urandom);
		wr(`VTR_ADDR_TRIM, d, 1'b1);
		chk("trim nv", trim, d);
		mst_u.start();
		chk("nv busy", {7'h0, nv_busy}, 8'h01);
		mst_u.xbyte(ID_W, r, a);
		chk("busy ack", {7'h0, a}, 8'h00);
		mst_u.stop();
		idle_wait();
		rd(`VTR_ADDR_TRIM, d);
		$display("test stored write done");
		wr(`VTR_ADDR_PTR, 8'h80, 1'b1);
		v = 8'($urandom) & 8'h7F;
		wr(`VTR_ADDR_TRIM, v, 1'b1);
		chk("trim pre", trim, v);
		mst_u.start();
		mst_u.xbyte(ID_W, r, a);
		mst_u.xbyte(`VTR_ADDR_TRIM, r, a);
		mst_u.bit_x(1'b1, a);
		mst_u.bit_x(1'b0, a);
		mst_u.stop();
		chk("trim cut", trim, `VTR_ERROR_SETTING);
		wr(`VTR_ADDR_TRIM, v, 1'b1);
		wr(8'h01, 8'h00, 1'b0);
		chk("trim err", trim, `VTR_ERROR_SETTING);
		mst_u.start();
		mst_u.xbyte(8'hA0, r, a);
		chk("bad id", {7'h0, a}, 8'h00);
		mst_u.stop();
		$display("test errors done");
		nrst_n <= 1'b0;
		repeat (12) @(posedge mclk);
		nrst_n <= 1'b1;
		@(posedge mclk);
		idle_wait();
		chk("trim reload", trim, d);
		rd(`VTR_ADDR_PTR, `VTR_PTR_RESET);
		rd(`VTR_ADDR_TRIM, d);
		$display("test second reset done");
		stop_test();
	end
endmodule // panel_common_voltage_trim_register_access_bench

`default_nettype wire
